// file: ocmd_decoder.sv
// Customer-side operations-channel message decoder core.
// Assumes frames arrive as one-cycle strobes from same-clock framing logic.
`timescale 1ns/1ns
`include "ocmd_params.svh"
// Overview of operation
// - Accept address 000 or 111 only
// - Unable-to-comply reply carries address 000
// - Code 50 loops both bearers plus signalling
// - Codes 51/52 loop single bearer, transparent
// - Code FF releases all latched actions
// - Reply AA for validated unsupported message
// - Code 53 corrupts CRC until normal
// - Hold code keeps everything unchanged
// - Improper address answered with hold code
// - Non-standard blocks 1x..4x set aside
// - Internal network blocks 6x..9x set aside
// - Other undefined codes stay reserved
// - Non-standard use never disturbs protocol
// - Frame is address, indicator, info byte
// - Act only after three identical frames
// - Echo each own/broadcast-address frame; UTC from third unknown
// - Actions latch, cleared by separate message
module ocmd_decoder
  import ocmd_pkg::*;
#(
  parameter bit SINGLE_LOOPS = 1'b1
)(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Received frame
  input  wire logic [11:0] rxFrame,
  input  wire logic        rxValid,
  // Reply frame
  output logic      [11:0] txFrame,
  output logic             txValid,
  // Latched maintenance actions
  output logic             loopAll,
  output logic             loopB1,
  output logic             loopB2,
  output logic             crcCorrupt,
  output logic             crcNotified
);
  //////////////////////////////////////////////////////////////////////
  typedef struct packed {
    ocmd_frame_t lastFrame;
    logic [1:0]  matchCnt;
    ocmd_frame_t tx;
    logic        txV;
    logic        lbAll;
    logic        lbB1;
    logic        lbB2;
    logic        crcReq;
    logic        crcNtf;
  } ocmd_state_t;

  ocmd_state_t st_ff;
  ocmd_state_t nxt_st;
  ocmd_link_if lnk ();

  //////////////////////////////////////////////////////////////////////
  // Reply frame builder
  function automatic ocmd_frame_t mkFrame(input logic [2:0] a, input logic [7:0] c);
    mkFrame = {a, 1'b1, c};
  endfunction

  // Own or broadcast address
  function automatic logic addrOk(input logic [2:0] a);
    addrOk = (a == `OCMD_ADDR_OWN) || (a == `OCMD_ADDR_BCAST);
  endfunction

  // Saturating identical-frame counter
  function automatic logic [1:0] nextCount(
    input logic       same,
    input logic [1:0] cnt
  );
    if (same && cnt != 2'h0) begin
      if (cnt != `OCMD_VALID_COUNT) begin
        nextCount = cnt + 2'h1;
      end else begin
        nextCount = cnt;
      end
    end else begin
      nextCount = 2'h1;
    end
  endfunction

  // Release every latched action
  function automatic ocmd_state_t clearActions(input ocmd_state_t s);
    clearActions        = s;
    clearActions.lbAll  = 1'b0;
    clearActions.lbB1   = 1'b0;
    clearActions.lbB2   = 1'b0;
    clearActions.crcReq = 1'b0;
    clearActions.crcNtf = 1'b0;
  endfunction

  // Latch one action by its code
  function automatic ocmd_state_t setAction(input ocmd_state_t s, input logic [7:0] c);
    setAction = s;
    case (c)
      `OCMD_CODE_LB_ALL: begin
        setAction.lbAll = 1'b1;
      end
      `OCMD_CODE_LB_B1: begin
        setAction.lbB1 = 1'b1;
      end
      `OCMD_CODE_LB_B2: begin
        setAction.lbB2 = 1'b1;
      end
      `OCMD_CODE_CRC_REQ: begin
        setAction.crcReq = 1'b1;
      end
      `OCMD_CODE_CRC_NTF: begin
        setAction.crcNtf = 1'b1;
      end
      default: begin
        setAction = s;
      end
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  // frame field split
  assign lnk.code     = rxFrame[`OCMD_INFO_HI:0];
  assign lnk.isMsg    = rxFrame[`OCMD_IND_BIT];
  assign lnk.b1Enable = SINGLE_LOOPS;

  ocmd_classifier u_cls (
    .lnk (lnk.clsf)
  );

  //////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [2:0] addr;
    logic       third;
    addr  = rxFrame[`OCMD_ADDR_HI:`OCMD_ADDR_LO];
    third = 1'b0;
    nxt_st = st_ff;
    nxt_st.txV = 1'b0;
    if (rxValid) begin
      nxt_st.txV = 1'b1;
      if (!addrOk(addr)) begin
        nxt_st.tx = mkFrame(`OCMD_ADDR_OWN, `OCMD_CODE_HOLD);
        nxt_st.matchCnt = 2'h0;
        nxt_st.lastFrame = `OCMD_RST_FRAME;
      end else begin
        nxt_st.matchCnt = nextCount(rxFrame == st_ff.lastFrame, st_ff.matchCnt);
        nxt_st.lastFrame = rxFrame;
        third = (nxt_st.matchCnt == `OCMD_VALID_COUNT);
        nxt_st.tx = rxFrame;
        if (third) begin
          case (lnk.cls)
            OCMD_CLS_UNSUP: begin
              nxt_st.tx = mkFrame(`OCMD_ADDR_OWN, `OCMD_CODE_UTC);
            end
            OCMD_CLS_NORM: begin
              nxt_st = clearActions(nxt_st);
            end
            OCMD_CLS_HOLD: begin
              nxt_st.lbAll = st_ff.lbAll;
            end
            OCMD_CLS_ACT: begin
              nxt_st = setAction(nxt_st, lnk.code);
            end
            default: nxt_st.tx = rxFrame;
          endcase
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Outputs straight from state

  assign txFrame     = st_ff.tx;
  assign txValid     = st_ff.txV;
  assign loopAll     = st_ff.lbAll;
  assign loopB1      = st_ff.lbB1;
  assign loopB2      = st_ff.lbB2;
  assign crcCorrupt  = st_ff.crcReq;
  assign crcNotified = st_ff.crcNtf;
endmodule

// file: ocmd_params.svh
// Constants for the operations-channel message decoder.
// Assumes inclusion by its bare name from the decoder files.
`ifndef OCMD_PARAMS_SVH
`define OCMD_PARAMS_SVH
`define OCMD_FRAME_W      12
`define OCMD_ADDR_HI      11
`define OCMD_ADDR_LO      9
`define OCMD_IND_BIT      8
`define OCMD_INFO_HI      7
`define OCMD_ADDR_OWN     3'h0
`define OCMD_ADDR_BCAST   3'h7
`define OCMD_CODE_LB_ALL  8'h50
`define OCMD_CODE_LB_B1   8'h51
`define OCMD_CODE_LB_B2   8'h52
`define OCMD_CODE_CRC_REQ 8'h53
`define OCMD_CODE_CRC_NTF 8'h54
`define OCMD_CODE_NORMAL  8'hFF
`define OCMD_CODE_HOLD    8'h00
`define OCMD_CODE_UTC     8'hAA
`define OCMD_VALID_COUNT  2'h3
`define OCMD_RST_FRAME    12'h000
`endif

// file: ocmd_pkg.sv
// Types for the operations-channel message decoder.
// Assumes the constants header is compiled alongside.
package ocmd_pkg;
  typedef logic [11:0] ocmd_frame_t;
  typedef enum logic [1:0] {
    OCMD_CLS_ACT  = 2'b00,
    OCMD_CLS_HOLD = 2'b01,
    OCMD_CLS_NORM = 2'b10,
    OCMD_CLS_UNSUP = 2'b11
  } ocmd_cls_t;
endpackage

// file: ocmd_link_if.sv
// Carrier between the decoder core and the code classifier.
// Assumes one clock domain; purely combinational signals.
`timescale 1ns/1ns
interface ocmd_link_if;
  import ocmd_pkg::*;
  logic [7:0] code;
  logic       isMsg;
  logic       b1Enable;
  ocmd_cls_t  cls;
  modport core (output code, output isMsg, output b1Enable, input cls);
  modport clsf (input code, input isMsg, input b1Enable, output cls);
endinterface

// file: ocmd_classifier.sv
// Classifies an information field into action, hold, normal or unsupported.
// Assumes combinational use inside the decoder core.
`timescale 1ns/1ns
`include "ocmd_params.svh"
module ocmd_classifier
  import ocmd_pkg::*;
(
  ocmd_link_if.clsf lnk
);
  //////////////////////////////////////////////////////////////////////
  always_comb begin
    lnk.cls = OCMD_CLS_UNSUP;
    if (!lnk.isMsg) begin
      lnk.cls = OCMD_CLS_UNSUP;
    end else begin
      case (lnk.code)
        `OCMD_CODE_LB_ALL,
        `OCMD_CODE_CRC_REQ,
        `OCMD_CODE_CRC_NTF: lnk.cls = OCMD_CLS_ACT;
        `OCMD_CODE_LB_B1,
        `OCMD_CODE_LB_B2: lnk.cls = lnk.b1Enable ? OCMD_CLS_ACT : OCMD_CLS_UNSUP;
        `OCMD_CODE_HOLD: lnk.cls = OCMD_CLS_HOLD;
        `OCMD_CODE_NORMAL: lnk.cls = OCMD_CLS_NORM;
        default: lnk.cls = OCMD_CLS_UNSUP;
      endcase
    end
  end
endmodule

// file: ocmd_net_model.sv
// Network line termination model.
// Assumes send is called just after a rising edge.
`timescale 1ns/1ns
module ocmd_net_model (
  // Clock
  input  wire logic        core_clk,
  // Frames to decoder
  output logic      [11:0] rxFrame,
  output logic             rxValid
);
  initial begin
    rxFrame = 12'h000;
    rxValid = 1'b0;
  end
  task automatic send(input logic [11:0] f, input int n);
    rxFrame = f;
    rxValid = 1'b1;
    repeat (n) @(posedge core_clk);
    #1;
    rxValid = 1'b0;
    rxFrame = ~f;
  endtask
endmodule

// file: ocmd_decoder_asserts.sv
// Port checker for the decoder.
// Assumes one clock, synchronous reset.
`timescale 1ns/1ns
module ocmd_decoder_asserts (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [11:0] rxFrame,
  input wire logic        rxValid,
  input wire logic [11:0] txFrame,
  input wire logic        txValid,
  input wire logic        loopAll,
  input wire logic        loopB1,
  input wire logic        loopB2,
  input wire logic        crcCorrupt,
  input wire logic        crcNotified
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  wire logic [4:0] lat = {loopAll, loopB1, loopB2, crcCorrupt, crcNotified};
  property p_reply; rxValid |=> txValid; endproperty
  a_reply: assert property (p_reply) else $error("no reply");
  property p_bad; rxValid && !(rxFrame[11:9] inside {3'h0, 3'h7}) |=> txFrame == 12'h100;
  endproperty
  a_bad: assert property (p_bad) else $error("bad address reply");
  property p_echo; txValid && $past(rxFrame[11:9]) inside {3'h0, 3'h7}
    && txFrame[7:0] != 8'hAA |-> txFrame == $past(rxFrame); endproperty
  a_echo: assert property (p_echo) else $error("echo wrong");
  property p_utc; txValid && txFrame[7:0] == 8'hAA && txFrame != $past(rxFrame)
    |-> txFrame[11:8] == 4'h1; endproperty
  a_utc: assert property (p_utc) else $error("refusal address");
  property p_stay; !txValid && !$past(sys_rst) |-> $stable(lat); endproperty
  a_stay: assert property (p_stay) else $error("latch moved");
  property p_hold; txValid && txFrame[8:0] == 9'h100 |-> $stable(lat); endproperty
  a_hold: assert property (p_hold) else $error("hold moved");
  property p_loop; $rose(loopAll) |-> txValid && txFrame[8:0] == 9'h150; endproperty
  a_loop: assert property (p_loop) else $error("loop cause");
  property p_crc; $rose(crcCorrupt) |-> txValid && txFrame[8:0] == 9'h153; endproperty
  a_crc: assert property (p_crc) else $error("crc cause");
  property p_norm; $fell(loopAll) || $fell(crcCorrupt) |-> txFrame[8:0] == 9'h1FF;
  endproperty
  a_norm: assert property (p_norm) else $error("release cause");
  c_loop: cover property ($rose(loopAll));
  c_utc: cover property (txValid && txFrame == 12'h1AA);
  c_bad: cover property (txValid && txFrame == 12'h100);
endmodule
bind ocmd_decoder ocmd_decoder_asserts i_chk (.core_clk, .sys_rst, .rxFrame, .rxValid,
  .txFrame, .txValid, .loopAll, .loopB1, .loopB2, .crcCorrupt, .crcNotified);

// file: ocmd_decoder_tb.sv
// Self-checking bench for the decoder.
// Assumes the network model drives all frames.
`timescale 1ns/1ns
module ocmd_decoder_tb;
  logic        core_clk = 1'b0;
  logic        sys_rst  = 1'b1;
  logic [11:0] rxFrame, txFrame, frm, prev;
  logic        rxValid, txValid, loopAll, loopB1, loopB2, crcCorrupt, crcNotified;
  logic [4:0]  expLat = 5'h00;
  logic [16:0] rnd = 17'h1334D;
  logic [11:0] corner [10] = '{12'h150, 12'h151, 12'hF52, 12'h153, 12'h154,
                               12'hE00, 12'h1FF, 12'h1AA, 12'h050, 12'h350};
  int          numErrors = 0, comparisons = 0, cyc = 0;
  ocmd_decoder i_dut (.core_clk, .sys_rst, .rxFrame, .rxValid, .txFrame, .txValid,
                      .loopAll, .loopB1, .loopB2, .crcCorrupt, .crcNotified);
  ocmd_net_model i_net (.core_clk, .rxFrame, .rxValid);
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc > 5000) begin
      numErrors++;
      endSim();
    end
  end
  function automatic logic [16:0] lfsr(input logic [16:0] x);
    return {x[15:0], x[16] ^ x[13]};
  endfunction
  function automatic logic [4:0] nextLat(input logic [4:0] l, input logic [8:0] c);
    case (c)
      9'h150: return l | 5'h10;
      9'h151: return l | 5'h08;
      9'h152: return l | 5'h04;
      9'h153: return l | 5'h02;
      9'h154: return l | 5'h01;
      9'h1FF: return 5'h00;
      default: return l;
    endcase
  endfunction
  task automatic chk(input logic [11:0] got, input logic [11:0] want, input string m);
    comparisons++;
    if (got !== want) begin
      numErrors++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic xfer(input logic [11:0] f, input int k);
    logic ok;
    logic kn;
    ok = f[11:9] inside {3'h0, 3'h7};
    kn = f[8:0] inside {9'h150, 9'h151, 9'h152, 9'h153, 9'h154, 9'h1FF, 9'h100};
    i_net.send(f, k);
    chk({11'h000, txValid}, 12'h001, "reply strobe");
    chk(txFrame, !ok ? 12'h100 : (k >= 3 && !kn) ? 12'h1AA : f, "reply");
    if (ok && k >= 3) expLat = nextLat(expLat, f[8:0]);
    chk({7'h00, loopAll, loopB1, loopB2, crcCorrupt, crcNotified}, {7'h00, expLat},
        "actions");
    prev = f;
    @(posedge core_clk);
    #1;
    chk({11'h000, txValid}, 12'h000, "strobe idle");
  endtask
  task automatic endSim();
    $display("errors %0d comparisons %0d", numErrors, comparisons);
    if (numErrors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    #1;
    sys_rst = 1'b0;
    foreach (corner[i]) xfer(corner[i], 3);
    repeat (60) begin
      rnd = lfsr(rnd);
      frm = rnd[2] ? corner[rnd[6:3] % 10] : rnd[16:5];
      if (rnd[1]) frm[11:9] = {3{rnd[0]}};
      if (frm === prev) frm[0] = ~frm[0];
      xfer(frm, rnd[12:11] + 1);
    end
    endSim();
  end
endmodule
